// >>> hbridge_stage_control.sv
/*
 Control logic of an H-bridge power stage: pin synchronisers, reset and
 protection state machine, fault and warning flags, two dead-time drivers.
 Assumes analog comparators deliver the error levels and supply-good level,
 and the gate driver turns the four switch enables into the bridge.
*/
`timescale 1ns/10ps
`include "hbridge_cfg.svh"

module hbridge_stage_control
    import hbridge_pkg::*;
#(
    parameter int DEAD_CYCLES = `DEAD_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reset_n,
    input wire logic pwm_in_a,
    input wire logic pwm_in_b,
    input wire logic gate_supply_good,
    input wire logic uv_error,
    input wire logic oc_error,
    input wire logic ot_error,
    input wire logic ot_warning,
    output logic high_a,
    output logic low_a,
    output logic high_b,
    output logic low_b,
    output logic fault_flag_n,
    output logic fault_flag_oe,
    output logic overtemp_warning_n,
    output logic overtemp_warning_oe
);

    localparam stage_state_s STATE_RESET = '{
        s1: `PIN_RESET_VALUE,
        s2: `PIN_RESET_VALUE,
        s3: `PIN_RESET_VALUE,
        filt: `PIN_RESET_VALUE,
        mode: ST_HOLD,
        flag_n: `FLAG_RESET_VALUE,
        warn_n: `WARN_RESET_VALUE
    };

    stage_state_s cur;
    stage_state_s next_cur;
    logic [`PIN_COUNT-1:0] pins;
    logic [`PIN_COUNT-1:0] differ;
    logic rst_hi;
    logic err_any;
    logic supply_ok;
    logic bridge_en;

    assign pins = {gate_supply_good, ot_warning, ot_error, oc_error, uv_error,
                   pwm_in_b, pwm_in_a, reset_n};

    // Filtered pin levels and derived conditions
    assign rst_hi = cur.filt[`PIN_RESET];
    assign supply_ok = cur.filt[`PIN_SUPPLY];
    assign err_any = cur.filt[`PIN_UV] | cur.filt[`PIN_OC] | cur.filt[`PIN_OT];

    always_comb begin
        next_cur = cur;
        // Three-stage synchroniser, change taken once stages two and three agree
        differ = cur.s2 ^ cur.s3;
        next_cur.s1 = pins;
        next_cur.s2 = cur.s1;
        next_cur.s3 = cur.s2;
        next_cur.filt = (~differ & cur.s3) | (differ & cur.filt);

        if (!supply_ok) begin
            next_cur.mode = ST_HOLD;
        end else begin
            case (cur.mode)
                ST_HOLD: begin
                    // Start-up Hi-Z until reset seen low
                    if (!rst_hi) begin
                        next_cur.mode = ST_READY;
                    end
                end
                ST_READY: begin
                    if (rst_hi) begin
                        next_cur.mode = err_any ? ST_FAULT : ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!rst_hi) begin
                        next_cur.mode = ST_READY;
                    end else if (err_any) begin
                        next_cur.mode = ST_FAULT;
                    end
                end
                ST_FAULT: begin
                    // Latch cleared on reset falling edge
                    if (!rst_hi) begin
                        next_cur.mode = ST_READY;
                    end
                end
                default: begin
                    next_cur.mode = ST_HOLD;
                end
            endcase
        end

        next_cur.flag_n = (next_cur.mode != ST_FAULT);
        next_cur.warn_n = ~(next_cur.filt[`PIN_WARN] & next_cur.filt[`PIN_SUPPLY]);

        // Switching only in run, never on the reserved both-high input
        bridge_en = (next_cur.mode == ST_RUN) &&
                    !(next_cur.filt[`PIN_PWM_A] && next_cur.filt[`PIN_PWM_B]);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cur <= STATE_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    dead_time_gen #(
        .DEAD_CYCLES(DEAD_CYCLES)
    ) half_a (
        .clk(clk),
        .sys_rst(sys_rst),
        .en(bridge_en),
        .demand(next_cur.filt[`PIN_PWM_A]),
        .high_on(high_a),
        .low_on(low_a)
    );

    dead_time_gen #(
        .DEAD_CYCLES(DEAD_CYCLES)
    ) half_b (
        .clk(clk),
        .sys_rst(sys_rst),
        .en(bridge_en),
        .demand(next_cur.filt[`PIN_PWM_B]),
        .high_on(high_b),
        .low_on(low_b)
    );

    // Open-drain flags, enable high while pulling low
    assign fault_flag_n = cur.flag_n;
    assign fault_flag_oe = ~cur.flag_n;
    assign overtemp_warning_n = cur.warn_n;
    assign overtemp_warning_oe = ~cur.warn_n;

    // Checks
    logic any_on;
    assign any_on = high_a | low_a | high_b | low_b;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_supply_clear: assert property (
        !supply_ok |=> (cur.mode == ST_HOLD) && fault_flag_n && !any_on)
        else $error("supply low did not clear stage");

    a_start_hiz: assert property (
        (cur.mode != ST_RUN) |-> !any_on)
        else $error("switching outside run");

    a_flag_hiz: assert property (
        !fault_flag_n |-> !any_on && fault_flag_oe)
        else $error("switching while fault flagged");

    a_reset_hiz: assert property (
        (supply_ok && !rst_hi && cur.mode != ST_FAULT) |=>
        !any_on && fault_flag_n)
        else $error("reset low not Hi-Z with flag high");

    a_drive_map: assert property (
        (cur.mode == ST_RUN && cur.filt[`PIN_PWM_A] && !cur.filt[`PIN_PWM_B])[*4] |->
        high_a && !low_a && low_b && !high_b)
        else $error("A high B low not mapped to bridge");

    a_drive_swap: assert property (
        (cur.mode == ST_RUN && !cur.filt[`PIN_PWM_A] && cur.filt[`PIN_PWM_B])[*4] |->
        low_a && !high_a && high_b && !low_b)
        else $error("A low B high not mapped to bridge");

    a_fault_latch: assert property (
        (cur.mode == ST_FAULT && rst_hi && supply_ok) |=> (cur.mode == ST_FAULT))
        else $error("fault latch lost with reset high");

    a_fault_clear: assert property (
        (cur.mode == ST_FAULT && !rst_hi && supply_ok) |=> (cur.mode == ST_READY)
        ##0 (rst_hi && !err_any && supply_ok) [*1] |=> (cur.mode == ST_RUN))
        else $error("fault not cleared by reset toggle");

    a_fault_flag: assert property (
        (cur.mode == ST_RUN && rst_hi && err_any && supply_ok) |=>
        !fault_flag_n && (cur.mode == ST_FAULT))
        else $error("error in run did not flag fault");

    a_run_entry: assert property (
        $rose(cur.mode == ST_RUN) |->
        $past(cur.mode == ST_READY) && $past(rst_hi && !err_any && supply_ok))
        else $error("run entered without clean reset release");

    a_fault_exit: assert property (
        $fell(cur.mode == ST_FAULT) |->
        $past(!rst_hi || !supply_ok))
        else $error("fault left with reset high");

    a_reset_flag: assert property (
        !rst_hi |=>
        fault_flag_n && !fault_flag_oe)
        else $error("reset low did not force flag high");

    a_ready_hiz: assert property (
        (cur.mode == ST_READY) |->
        fault_flag_n && !any_on)
        else $error("switching or flag low while in reset");

    a_run_flag: assert property (
        (cur.mode == ST_RUN) |->
        fault_flag_n && !fault_flag_oe)
        else $error("flag low during normal operation");

    c_run: cover property ((cur.mode == ST_READY) ##1 (cur.mode == ST_RUN));
    c_fault: cover property ((cur.mode == ST_RUN) ##1 (cur.mode == ST_FAULT));
    c_recover: cover property ((cur.mode == ST_FAULT) ##1 (cur.mode == ST_READY)
        ##[1:50] (cur.mode == ST_RUN));
    c_warn: cover property (!overtemp_warning_n && cur.mode == ST_RUN);

endmodule // hbridge_stage_control

// >>> hbridge_cfg.svh
/*
 Constants for the H-bridge stage control: pin bit positions, reset values, timing.
 Assumes a single 25 MHz clock and that the includer has the package types.
*/
`ifndef HBRIDGE_CFG_SVH
`define HBRIDGE_CFG_SVH

`define CLK_PERIOD_NS 40
`define DEAD_TIME_NS 80
`define DEAD_CYCLES ((`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define PIN_COUNT 8
`define PIN_RESET 0
`define PIN_PWM_A 1
`define PIN_PWM_B 2
`define PIN_UV 3
`define PIN_OC 4
`define PIN_OT 5
`define PIN_WARN 6
`define PIN_SUPPLY 7

`define PIN_RESET_VALUE 8'h40
`define FLAG_RESET_VALUE 1'b1
`define WARN_RESET_VALUE 1'b1

`endif

// >>> hbridge_pkg.sv
/*
 Types for the H-bridge stage control.
 Assumes hbridge_cfg.svh supplies the pin count.
*/
`include "hbridge_cfg.svh"

package hbridge_pkg;

    typedef enum logic [1:0] {
        ST_HOLD,
        ST_READY,
        ST_RUN,
        ST_FAULT
    } stage_mode_e;

    typedef struct packed {
        logic [`PIN_COUNT-1:0] s1;
        logic [`PIN_COUNT-1:0] s2;
        logic [`PIN_COUNT-1:0] s3;
        logic [`PIN_COUNT-1:0] filt;
        stage_mode_e mode;
        logic flag_n;
        logic warn_n;
    } stage_state_s;

endpackage

// >>> dead_time_gen.sv
/*
 One half-bridge switch driver with dead time between high and low side.
 Assumes demand and en come from logic on the same clock.
*/
`timescale 1ns/10ps
`include "hbridge_cfg.svh"

module dead_time_gen #(
    parameter int DEAD_CYCLES = `DEAD_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic en,
    input wire logic demand,
    output logic high_on,
    output logic low_on
);
    localparam int CW = $clog2(DEAD_CYCLES + 1);
    localparam logic [CW-1:0] DEAD_LOAD = CW'(DEAD_CYCLES);

    typedef struct packed {
        logic high_on;
        logic low_on;
        logic side;
        logic [CW-1:0] count;
    } dead_state_s;

    localparam dead_state_s DEAD_RESET = '{high_on: 1'b0, low_on: 1'b0, side: 1'b0,
                                            count: DEAD_LOAD};

    dead_state_s cur;
    dead_state_s next_cur;

    always_comb begin
        next_cur = cur;
        if (!en) begin
            next_cur.high_on = 1'b0;
            next_cur.low_on = 1'b0;
            next_cur.count = DEAD_LOAD;
        end else if (demand != cur.side) begin
            next_cur.high_on = 1'b0;
            next_cur.low_on = 1'b0;
            next_cur.side = demand;
            next_cur.count = DEAD_LOAD;
        end else if (cur.count != '0) begin
            next_cur.count = cur.count - CW'(1);
        end else begin
            next_cur.high_on = cur.side;
            next_cur.low_on = ~cur.side;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cur <= DEAD_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    assign high_on = cur.high_on;
    assign low_on = cur.low_on;

    a_never_both: assert property (@(posedge clk) disable iff (sys_rst)
        !(high_on && low_on)) else $error("both switches on");

    a_dead_gap: assert property (@(posedge clk) disable iff (sys_rst)
        ($rose(high_on) || $rose(low_on)) |->
        ($past(!high_on && !low_on, 1) && $past(!high_on && !low_on, 2)))
        else $error("dead time too short");

    c_high_on: cover property (@(posedge clk) disable iff (sys_rst) $rose(high_on));

endmodule // dead_time_gen

// >>> pwm_ctrl_model.sv
/*
 Model of the PWM modulator and system controller facing the stage.
 Assumes the stage clock; drives its pins at the falling edge.
*/
`timescale 1ns/10ps

module pwm_ctrl_model #(
    parameter int PRECHARGE = 25000,
    parameter int HALF = 32
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic gate_supply_good,
    input wire logic run_req,
    input wire logic hold_reset,
    output logic reset_n,
    output logic pwm_in_a,
    output logic pwm_in_b
);
    int pre_cnt;
    int ph_cnt;
    int lag;
    logic streaming;
    logic phase;
    always @(negedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_cnt <= 0;
            ph_cnt <= 0;
            lag <= 0;
            streaming <= 1'b0;
            phase <= 1'b0;
            reset_n <= 1'b0;
            pwm_in_a <= 1'b0;
            pwm_in_b <= 1'b0;
        end else begin
            // Precharge timer from supply good
            pre_cnt <= !gate_supply_good ? 0 :
                       (pre_cnt < PRECHARGE ? pre_cnt + 1 : pre_cnt);
            lag <= run_req ? 0 : (lag < 16 ? lag + 1 : lag);
            streaming <= run_req | (streaming & (lag < 16));
            ph_cnt <= (ph_cnt == HALF - 1) ? 0 : ph_cnt + 1;
            phase <= (ph_cnt == HALF - 1) ? ~phase : phase;
            pwm_in_a <= streaming & phase;
            pwm_in_b <= streaming & ~phase;
            reset_n <= run_req & ~hold_reset & streaming &
                       (pre_cnt == PRECHARGE);
        end
    end
endmodule // pwm_ctrl_model

// >>> hbridge_stage_control_bench.sv
/*
 Self-checking bench for the H-bridge stage control with its controller model.
 Assumes the stage package, the stage and the controller model compile first.
*/
`timescale 1ns/10ps

module hbridge_stage_control_bench;
    localparam int DT = 2;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic gate_supply_good = 1'b0;
    logic run_req = 1'b0;
    logic hold_reset = 1'b0;
    logic [2:0] err = 3'h0;
    logic ot_warning = 1'b0;
    logic reset_n, pwm_in_a, pwm_in_b, high_a, low_a, high_b, low_b;
    logic fault_flag_n, fault_flag_oe, overtemp_warning_n, overtemp_warning_oe;
    int n_fail = 0;
    int samples_checked = 0;
    wire logic [3:0] sw = {high_a, low_a, high_b, low_b};

    always #20 clk = ~clk;

    pwm_ctrl_model pwm_ctrl_model_i (.clk(clk), .sys_rst(sys_rst),
        .gate_supply_good(gate_supply_good), .run_req(run_req), .hold_reset(hold_reset),
        .reset_n(reset_n), .pwm_in_a(pwm_in_a), .pwm_in_b(pwm_in_b));
    hbridge_stage_control #(.DEAD_CYCLES(DT)) hbridge_stage_control_i (.clk(clk),
        .sys_rst(sys_rst), .reset_n(reset_n), .pwm_in_a(pwm_in_a), .pwm_in_b(pwm_in_b),
        .gate_supply_good(gate_supply_good), .uv_error(err[0]), .oc_error(err[1]),
        .ot_error(err[2]), .ot_warning(ot_warning), .high_a(high_a), .low_a(low_a),
        .high_b(high_b), .low_b(low_b), .fault_flag_n(fault_flag_n),
        .fault_flag_oe(fault_flag_oe), .overtemp_warning_n(overtemp_warning_n),
        .overtemp_warning_oe(overtemp_warning_oe));

    task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wait_flag(input logic v);
        for (int i = 0; i < 40 && fault_flag_n !== v; i++) begin
            cyc(1);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic t_startup;
        check("start hi-z", sw, 4'h0);
        gate_supply_good = 1'b1;
        run_req = 1'b1;
        err[1] = 1'b1;
        cyc(200);
        check("precharge hi-z", sw, 4'h0);
        check("flag oe", {1'h0, fault_flag_n, fault_flag_oe, overtemp_warning_oe}, 4'h4);
        err[1] = 1'b0;
        for (int i = 0; i < 30000 && reset_n !== 1'b1; i++) begin
            cyc(1);
        end
        $display("test done: startup");
    endtask

    task automatic t_switch;
        int stable;
        int off_run;
        logic [1:0] pw;
        logic [1:0] last_a;
        stable = 0;
        off_run = 0;
        pw = 2'h0;
        last_a = 2'h0;
        for (int i = 0; i < 300; i++) begin
            cyc(1);
            stable = ({pwm_in_a, pwm_in_b} === pw) ? stable + 1 : 0;
            pw = {pwm_in_a, pwm_in_b};
            if (stable == 12) check("map", sw, (pw == 2'h2) ? 4'h9 : 4'h6);
            if ((high_a & low_a) | (high_b & low_b)) check("overlap", sw, 4'h0);
            if (high_a | low_a) begin
                if (last_a != 2'h0 && last_a != {high_a, low_a}) begin
                    check("dead a", {3'h0, off_run >= DT}, 4'h1);
                end
                last_a = {high_a, low_a};
                off_run = 0;
            end else begin
                off_run++;
            end
        end
        $display("test done: switching");
    endtask

    task automatic t_fault;
        for (int e = 0; e < 3; e++) begin
            err[e] = 1'b1;
            wait_flag(1'b0);
            cyc(2);
            check("flag set", {2'h0, fault_flag_n, fault_flag_oe}, 4'h1);
            err[e] = 1'b0;
            for (int i = 0; i < 40; i++) begin
                cyc(1);
                check("hi-z in fault", sw, 4'h0);
            end
            check("latched", {3'h0, fault_flag_n}, 4'h0);
            hold_reset = 1'b1;
            wait_flag(1'b1);
            cyc(4);
            check("cleared", {fault_flag_n, fault_flag_oe, 2'h0}, 4'h8);
            check("muted", sw, 4'h0);
            hold_reset = 1'b0;
            for (int i = 0; i < 60 && sw === 4'h0; i++) begin
                cyc(1);
            end
            check("resumed", {3'h0, sw != 4'h0}, 4'h1);
        end
        ot_warning = 1'b1;
        cyc(8);
        check("warning", {2'h0, overtemp_warning_n, overtemp_warning_oe}, 4'h1);
        ot_warning = 1'b0;
        $display("test done: fault");
    endtask

    task automatic t_down;
        run_req = 1'b0;
        cyc(10);
        check("down order", {2'h0, reset_n, pwm_in_a | pwm_in_b}, 4'h1);
        check("down hi-z", sw, 4'h0);
        gate_supply_good = 1'b0;
        cyc(10);
        check("supply off flag", {3'h0, fault_flag_n}, 4'h1);
        check("supply off", sw, 4'h0);
        $display("test done: powerdown");
    endtask

    initial begin
        cyc(10);
        sys_rst = 1'b0;
        cyc(2);
        t_startup();
        t_switch();
        t_fault();
        t_down();
        results();
    end

    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        results();
    end
endmodule // hbridge_stage_control_bench
